// File: design/divdcc_top.sv
`timescale 1ns/10ps
// Operation
// - correction off, both bypassed: prescaler duty
// - only second bypassed: first stage sets duty
// - both active: second stage sets duty
// - correction on gives fifty percent duty
// - correction on, even prescaler gives fifty percent
// - correction on, odd first stage: fifty percent
// - odd first, even second: fifty percent
// - fields hold cycle count minus one
// - correction on after reset, bit disables
// - channel ratio from bypass and stage ratios
module divdcc_top
  import divdcc_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // divided clock, one pclk is half an input clock cycle
  output logic             clk_out
);

  // ****************************************
  // bus decode
  // ****************************************
  logic        setup;
  logic        wr_en;
  logic        hit_ctrl;
  logic        hit_s1;
  logic        hit_s2;
  logic        hit_st;
  logic        mapped;
  logic [31:0] rd_mux;
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  chan_cfg_t   ctrl_q;
  stage_cfg_t  s1_q;
  stage_cfg_t  s2_q;
  logic        restart_q;

  assign setup    = psel & ~penable & ~pready_q;
  assign hit_ctrl = (paddr == CTRL_OFS);
  assign hit_s1   = (paddr == STAGE1_OFS);
  assign hit_s2   = (paddr == STAGE2_OFS);
  assign hit_st   = (paddr == STATUS_OFS);
  assign mapped   = hit_ctrl | hit_s1 | hit_s2 | hit_st;
  assign wr_en    = setup & pwrite & mapped;

  // ****************************************
  // ratio and duty arithmetic
  // ****************************************
  logic [5:0]       d1;
  logic [5:0]       d2;
  logic [2:0]       pre;
  logic [10:0]      chan;
  logic [CNT_W-1:0] half;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] hi_off;
  logic [CNT_W-1:0] high_len;
  logic             cfg_err;
  logic             wave;

  assign d1  = stage_ratio(s1_q);
  assign d2  = stage_ratio(s2_q);
  assign pre = (ctrl_q.pre_ratio == 3'h0) ? 3'h1 : ctrl_q.pre_ratio;

  // bypassing only the first stage is misuse; the second then divides alone
  assign chan = (ctrl_q.byp1 & ctrl_q.byp2) ? 11'h001 :
                ctrl_q.byp2 ? 11'(d1) :
                ctrl_q.byp1 ? 11'(d2) :
                11'(d1) * 11'(d2);

  assign half   = 16'(pre) * 16'(chan);
  assign period = 16'(half << 1);

  // correction off, both stages bypassed: prescaler odd above one drops one half cycle, as its own output does
  assign hi_off = (ctrl_q.byp1 & ctrl_q.byp2) ?
                    ((pre == 3'h1) ? 16'h0001 :
                     (pre[0] ? 16'(pre) - 16'h0001 : 16'(pre))) :
                  ctrl_q.byp2 ? 16'(16'(pre) * 16'(s1_q.high + 5'h01) * 16'h0002) :
                  ctrl_q.byp1 ? 16'(16'(pre) * 16'(s2_q.high + 5'h01) * 16'h0002) :
                  16'(16'(pre) * 16'(d1) * 16'(s2_q.high + 5'h01) * 16'h0002);

  // with the input at half duty, correction lands exactly on half the period
  assign high_len = ctrl_q.cdis ? hi_off : half;

  // flags a setup that correction cannot honour
  assign cfg_err = ~ctrl_q.cdis &
                   (((~ctrl_q.byp1) & stage_bad(s1_q)) |
                    ((~ctrl_q.byp2) & stage_bad(s2_q)) |
                    (ctrl_q.byp1 & ~ctrl_q.byp2) |
                    (~ctrl_q.byp1 & ~ctrl_q.byp2 & ~d1[0] & d2[0]));

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl)
      rd_mux = 32'(ctrl_q.cdis) << CDIS_BIT | 32'(ctrl_q.byp1) << BYP1_BIT
             | 32'(ctrl_q.byp2) << BYP2_BIT | 32'(ctrl_q.pre_ratio) << PRE_LSB;
    else if (hit_s1)
      rd_mux = 32'(s1_q);
    else if (hit_s2)
      rd_mux = 32'(s2_q);
    else if (hit_st)
      rd_mux = 32'(wave) << ST_OUT_BIT | 32'(cfg_err) << ST_ERR_BIT
             | 32'(chan) << ST_RAT_LSB;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      restart_q <= 1'b0;
    end
    else
    begin
      pready_q  <= setup;
      prdata_q  <= setup ? rd_mux : prdata_q;
      pslverr_q <= setup & ~mapped;
      restart_q <= wr_en & ~hit_st;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= chan_cfg_t'({CTRL_RST[PRE_LSB +: PRE_W], CTRL_RST[BYP2_BIT],
                             CTRL_RST[BYP1_BIT], CTRL_RST[CDIS_BIT]});
      s1_q   <= stage_cfg_t'(STAGE_RST);
      s2_q   <= stage_cfg_t'(STAGE_RST);
    end
    else if (wr_en)
    begin
      if (hit_ctrl)
        ctrl_q <= chan_cfg_t'({pwdata[PRE_LSB +: PRE_W], pwdata[BYP2_BIT],
                               pwdata[BYP1_BIT], pwdata[CDIS_BIT]});
      if (hit_s1)
        s1_q <= stage_cfg_t'(pwdata[7:0]);
      if (hit_s2)
        s2_q <= stage_cfg_t'(pwdata[7:0]);
    end
  end

  wave_shaper u_shaper
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .period   (period),
    .high_len (high_len),
    .restart  (restart_q),
    .wave     (wave)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clk_out <= 1'b0;
    else
      clk_out <= wave;
  end

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  // ****************************************
  // checking
  // ****************************************
  half_duty_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_q.cdis |-> (high_len + high_len == period))
    else $error("corrected duty is not half the period");

  pre_odd_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q.cdis && ctrl_q.byp1 && ctrl_q.byp2 && pre == 3'h3)
      |-> (high_len == 16'h0002 && period == 16'h0006))
    else $error("prescaler three duty not one third");

  pre_five_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q.cdis && ctrl_q.byp1 && ctrl_q.byp2 && pre == 3'h5) |-> (high_len == 16'h0004))
    else $error("prescaler five duty not two fifths");

  first_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q.cdis && !ctrl_q.byp1 && ctrl_q.byp2)
      |-> (high_len * 16'(d1) == period * 16'(s1_q.high + 5'h01)))
    else $error("first stage duty wrong");

  second_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q.cdis && !ctrl_q.byp1 && !ctrl_q.byp2)
      |-> (high_len * 16'(d2) == period * 16'(s2_q.high + 5'h01)))
    else $error("second stage duty wrong");

  ratio_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl_q.byp1 && !ctrl_q.byp2)
      |-> (period == 16'(16'h0002 * 16'(pre) * 16'(d1) * 16'(d2))))
    else $error("channel ratio not the product");

  odd_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl_q.cdis && ctrl_q.byp2 && s1_q.low == s1_q.high + 4'h1) |-> !cfg_err)
    else $error("legal odd first stage flagged");

  rule_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl_q.cdis && ctrl_q.byp1 && !ctrl_q.byp2) |-> cfg_err)
    else $error("first-only bypass not flagged");

  reload_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && !hit_st) |=> ##1 (u_shaper.hi_q == $past(high_len)))
    else $error("new setting not loaded after write");

endmodule

// File: design/wave_shaper.sv
`timescale 1ns/10ps
module wave_shaper
  import divdcc_pkg::*;
(
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // shape request
  input  wire logic [CNT_W-1:0] period,
  input  wire logic [CNT_W-1:0] high_len,
  input  wire logic             restart,
  // shaped level
  output logic                  wave
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] per_q;
  logic [CNT_W-1:0] per_d;
  logic [CNT_W-1:0] hi_q;
  logic [CNT_W-1:0] hi_d;
  logic             out_q;
  logic             wrap;
  logic [CNT_W-1:0] run_q;
  logic             clean_q;

  // new settings take effect at a period boundary, or at once on restart after a register write
  assign wrap  = (cnt_q == per_q - 16'h0001) | restart;
  assign cnt_d = wrap ? '0 : cnt_q + 16'h0001;
  assign per_d = wrap ? period : per_q;
  assign hi_d  = wrap ? high_len : hi_q;
  assign wave  = out_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= '0;
      per_q <= PERIOD_RST;
      hi_q  <= HIGH_RST;
      out_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      per_q <= per_d;
      hi_q  <= hi_d;
      out_q <= (cnt_d < hi_d);
    end
  end

  // ****************************************
  // checking
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_q   <= '0;
      clean_q <= 1'b0;
    end
    else
    begin
      run_q   <= (cnt_d < hi_d) ? run_q + 16'h0001 : '0;
      clean_q <= restart ? 1'b0 : (wrap ? 1'b1 : clean_q);
    end
  end

  high_run_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($fell(out_q) && clean_q && $past(clean_q)) |-> ($past(run_q) == hi_q))
    else $error("high phase length differs from high count");

  period_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clean_q && !restart && cnt_q == per_q - 16'h0001) |=> (cnt_q == '0 && out_q))
    else $error("period did not restart high");

endmodule

// File: pkg/divdcc_pkg.sv
package divdcc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0]  CTRL_OFS    = 8'h00;
  localparam logic [7:0]  STAGE1_OFS  = 8'h04;
  localparam logic [7:0]  STAGE2_OFS  = 8'h08;
  localparam logic [7:0]  STATUS_OFS  = 8'h0C;

  // control fields
  localparam int          CDIS_BIT    = 0;
  localparam int          BYP1_BIT    = 4;
  localparam int          BYP2_BIT    = 5;
  localparam int          PRE_LSB     = 8;
  localparam int          PRE_W       = 3;

  // status fields
  localparam int          ST_OUT_BIT  = 0;
  localparam int          ST_ERR_BIT  = 1;
  localparam int          ST_RAT_LSB  = 16;

  // stage fields: low count in [7:4], high count in [3:0]
  localparam int          LOW_LSB     = 4;
  localparam int          HIGH_LSB    = 0;

  // ****************************************
  // reset values and widths
  // ****************************************
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [7:0]  STAGE_RST   = 8'h00;
  localparam int          CNT_W       = 16;
  localparam logic [15:0] PERIOD_RST  = 16'h0002;
  localparam logic [15:0] HIGH_RST    = 16'h0001;

  typedef struct packed {
    logic [3:0] low;
    logic [3:0] high;
  } stage_cfg_t;

  typedef struct packed {
    logic [2:0] pre_ratio;
    logic       byp2;
    logic       byp1;
    logic       cdis;
  } chan_cfg_t;

  // stored counts are cycles minus one, so the ratio is low + high + 2
  function automatic logic [5:0] stage_ratio(input stage_cfg_t s);
    stage_ratio = 6'(s.low) + 6'(s.high) + 6'h02;
  endfunction

  // correction needs low == high (even) or low == high + 1 (odd)
  function automatic logic stage_bad(input stage_cfg_t s);
    if (s.low[0] == s.high[0])
      stage_bad = (s.low != s.high);
    else
      stage_bad = (s.low != s.high + 4'h1);
  endfunction

endpackage

// File: sim/cascaded_divider_duty_correction_bench.sv
`timescale 1ns/10ps
module cascaded_divider_duty_correction_bench
  import divdcc_pkg::*;
;
  // ****
  // stimulus, expectations and verdict
  // ****
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        clk_out;
  logic [15:0] high_len;
  logic [15:0] period_len;
  logic [15:0] rises;
  logic [31:0] rd;
  logic        er;
  chan_cfg_t   cc;
  stage_cfg_t  s1;
  stage_cfg_t  s2;
  int          err_total;
  int          comparisons;
  int          m;
  // {error expected, control, stage 1, stage 2}
  logic [27:0] corner [15] = '{
    28'h0070000, 28'h01F0000, 28'h02F0000, 28'h0270000,
    28'h01E0000, 28'h1020000, 28'h1000010, 28'h1042000,
    28'h1043000, 28'h0112110, 28'h0052100, 28'h0381011,
    28'h0030021, 28'h1001120, 28'h01C1000};

  divdcc_top divdcc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .clk_out(clk_out));
  clk_load_model clk_load_model_inst (.pclk(pclk), .presetn(presetn),
    .clk_in(clk_out), .high_len(high_len), .period_len(period_len), .rises(rises));

  task automatic end_sim();
    $display("checks=%0d errors=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, pready}, 32'h1);
  endtask

  // sel 0 period, 1 high time, 2 channel ratio; one pclk is half an input cycle
  function automatic int shape(input chan_cfg_t c, input stage_cfg_t a,
                               input stage_cfg_t b, input int sel);
    int p;
    int d1;
    int ch;
    int hi;
    p  = (c.pre_ratio == 3'h0) ? 1 : int'(c.pre_ratio);
    d1 = a.low + a.high + 2;
    ch = c.byp1 ? (c.byp2 ? 1 : b.low + b.high + 2) : (c.byp2 ? d1 : d1 * (b.low + b.high + 2));
    if (!c.cdis)
      hi = p * ch;
    else if (c.byp1 && c.byp2)
      hi = (p == 1) ? 1 : p - p % 2;
    else if (c.byp2)
      hi = 2 * p * (a.high + 1);
    else
      hi = 2 * p * (c.byp1 ? 1 : d1) * (b.high + 1);
    shape = (sel == 0) ? 2 * p * ch : (sel == 1) ? hi : ch;
  endfunction

  task automatic run_cfg(input logic e_exp);
    int n;
    apb(1'b1, STAGE1_OFS, {24'h0, s1});
    apb(1'b1, STAGE2_OFS, {24'h0, s2});
    apb(1'b1, CTRL_OFS, {21'h0, cc.pre_ratio, 2'b00, cc.byp2, cc.byp1, 3'b000, cc.cdis});
    n = rises + 3;
    repeat (20000) if (rises < n) @(posedge pclk);
    chk({31'h0, rises >= n}, 32'h1);
    chk(period_len, shape(cc, s1, s2, 0));
    chk(high_len, shape(cc, s1, s2, 1));
    apb(1'b0, STATUS_OFS, 32'h0);
    chk({31'h0, rd[ST_ERR_BIT]}, {31'h0, e_exp});
    chk({21'h0, rd[26:16]}, shape(cc, s1, s2, 2));
  endtask

  // default shape after any reset: correction on, both stages divide by two
  task automatic chk_reset();
    repeat (20000) if (rises < 16'h0003) @(posedge pclk);
    chk({31'h0, rises >= 16'h0003}, 32'h1);
    chk(period_len, 32'h8);
    chk(high_len, 32'h4);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial
  begin
    #2_400_000;
    err_total++;
    end_sim();
  end

  initial
  begin
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    err_total   = 0;
    comparisons = 0;
    void'($urandom(33));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk_reset();
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, er}, 32'h1);
    foreach (corner[i])
    begin
      cc = chan_cfg_t'(corner[i][21:16]);
      s1 = corner[i][15:8];
      s2 = corner[i][7:0];
      run_cfg(corner[i][24]);
    end
    // a reset in mid-run must drop the last corner's setting
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk_reset();
    repeat (12)
    begin
      m            = $urandom_range(0, 2);
      cc.cdis      = 1'($urandom_range(0, 1));
      cc.byp2      = (m > 0);
      cc.byp1      = (m == 2);
      cc.pre_ratio = 3'($urandom_range(0, 7));
      s1.high      = 4'($urandom_range(0, 3));
      s1.low       = s1.high + 4'($urandom_range(0, 1));
      s2.high      = 4'($urandom_range(0, 3));
      s2.low       = s2.high + 4'($urandom_range(0, 1));
      if (m == 0 && s1.low == s1.high)
        s2.low = s2.high;
      run_cfg(1'b0);
    end
    end_sim();
  end
endmodule

// File: sim/clk_load_model.sv
`timescale 1ns/10ps
module clk_load_model
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // received clock
  input  wire logic        clk_in,
  // measured shape in pclk cycles
  output logic      [15:0] high_len,
  output logic      [15:0] period_len,
  output logic      [15:0] rises
);
  // ****
  // load that times each high phase and each period
  // ****
  logic        prev_q;
  logic [15:0] run_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_q     <= 1'b0;
      run_q      <= 16'h0000;
      high_len   <= 16'h0000;
      period_len <= 16'h0000;
      rises      <= 16'h0000;
    end
    else
    begin
      prev_q <= clk_in;
      run_q  <= (clk_in && !prev_q) ? 16'h0001 : run_q + 16'h0001;
      if (clk_in && !prev_q)
      begin
        period_len <= run_q;
        rises      <= rises + 16'h0001;
      end
      if (!clk_in && prev_q)
        high_len <= run_q;
    end
  end
endmodule
